// ### logic/rcp_top.sv
// DDR read capture path: strobe capture, three-stage pipeline, sample flop, APB registers
`timescale 1ns/1ps
module rcp_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic capture_clk,
   input wire logic [rcp_pkg::DATA_W-1:0] memory_data_lines,
   input wire logic [rcp_pkg::CHECK_W-1:0] check_bit_lines,
   output logic memory_clock_out,
   output logic [rcp_pkg::TAP_W-1:0] read_clock_delay_taps,
   output logic ecc_check_en,
   output logic sample_valid,
   output rcp_pkg::rcp_pair_s sample_pair
);
   // Binary to gray
   function automatic logic [rcp_pkg::PTR_W-1:0] bin2gray(input logic [rcp_pkg::PTR_W-1:0] b);
      bin2gray = b ^ (b >> 1);
   endfunction

   // Gray to binary
   function automatic logic [rcp_pkg::PTR_W-1:0] gray2bin(input logic [rcp_pkg::PTR_W-1:0] g);
      logic [rcp_pkg::PTR_W-1:0] b;
      b = '0;
      for (int i = rcp_pkg::PTR_W - 1; i >= 0; i--) begin
         b[i] = g[i] ^ ((i == rcp_pkg::PTR_W - 1) ? 1'b0 : b[i+1]);
      end
      gray2bin = b;
   endfunction

   // ---------------- Link side, on the delayed strobe ----------------
   // Inverted strobe clocks the falling-edge beat
   logic capture_clk_n;
   // Rising-edge beat, the high half of a pair
   rcp_pkg::rcp_beat_s rise_q;
   rcp_pkg::rcp_beat_s rise_d;
   // Write pointer, binary and gray
   logic [rcp_pkg::PTR_W-1:0] wptr_q;
   logic [rcp_pkg::PTR_W-1:0] wptr_d;
   logic [rcp_pkg::PTR_W-1:0] wgray_q;
   logic [rcp_pkg::PTR_W-1:0] wgray_d;
   rcp_pkg::rcp_pair_s link_pair;

   assign capture_clk_n = ~capture_clk;

   // Next values on the link side
   always_comb begin
      rise_d.data = memory_data_lines;
      rise_d.check = check_bit_lines;
      link_pair.hi = rise_q;
      link_pair.lo.data = memory_data_lines;
      link_pair.lo.check = check_bit_lines;
      wptr_d = wptr_q + 1'b1;
      wgray_d = bin2gray(wptr_d);
   end

   // Rising beat latched on delayed strobe
   always_ff @(posedge capture_clk or negedge presetn) begin
      if (!presetn) begin
         rise_q <= '0;
      end else begin
         rise_q <= rise_d;
      end
   end

   // Each falling strobe edge closes a pair
   always_ff @(posedge capture_clk_n or negedge presetn) begin
      if (!presetn) begin
         wptr_q <= '0;
         wgray_q <= '0;
      end else begin
         wptr_q <= wptr_d;
         wgray_q <= wgray_d;
      end
   end

   // ---------------- Crossing into the bus clock ----------------
   logic [rcp_pkg::PTR_W-1:0] wgray_sync;
   logic [rcp_pkg::PTR_W-1:0] rptr_q;
   logic [rcp_pkg::PTR_W-1:0] rptr_d;
   rcp_pkg::rcp_pair_s ring_out;
   logic ring_take;

   // Stage one: the strobe-written capture ring
   rcp_ring #(
      .W(rcp_pkg::PAIR_W),
      .AW(rcp_pkg::RING_AW)
   ) u_ring (
      .wclk(capture_clk_n),
      .we(1'b1),
      .waddr(wptr_q[rcp_pkg::RING_AW-1:0]),
      .wdata(link_pair),
      .rclk(pclk),
      .raddr(rptr_q[rcp_pkg::RING_AW-1:0]),
      .rdata(ring_out)
   );

   // Gray write pointer to the bus clock
   rcp_sync #(
      .W(rcp_pkg::PTR_W)
   ) u_wptr_sync (
      .clk(pclk),
      .rst_n(presetn),
      .async_in(wgray_q),
      .sync_out(wgray_sync)
   );

   // ---------------- Register file ----------------
   rcp_pkg::rcp_timing_s timing_q;
   rcp_pkg::rcp_timing_s timing_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic slverr_q;
   logic slverr_d;
   logic [15:0] count_q;
   logic [15:0] count_d;
   logic setup_rd;
   logic access_wr;
   logic mapped;

   // ---------------- Bus clock pipeline ----------------
   rcp_pkg::rcp_pair_s stage1_pair;
   rcp_pkg::rcp_pair_s stage2_q;
   rcp_pkg::rcp_pair_s stage2_d;
   rcp_pkg::rcp_pair_s stage3_q;
   rcp_pkg::rcp_pair_s stage3_d;
   rcp_pkg::rcp_pair_s read_sample_point_flop_q;
   rcp_pkg::rcp_pair_s read_sample_point_flop_d;
   logic s1_valid_q;
   logic s1_valid_d;
   logic s2_valid_q;
   logic s2_valid_d;
   logic s3_valid_q;
   logic s3_valid_d;
   logic read_sample_point_flop_valid_q;
   logic read_sample_point_flop_valid_d;
   rcp_pkg::rcp_stage_e eff_stage;
   logic [1:0] eff_code;
   logic [rcp_pkg::TAP_W-1:0] taps;
   logic [3:0] fine_clamped;

   // Stage selection and read clock delay
   always_comb begin
      // Fine field limited to half a cycle
      fine_clamped = (timing_q.fine > rcp_pkg::FINE_HALF_STEPS) ?
         rcp_pkg::FINE_HALF_STEPS : timing_q.fine;
      // Half bit adds half a cycle
      if (timing_q.half) begin
         taps = {1'b0, rcp_pkg::FINE_HALF_STEPS} + {1'b0, fine_clamped};
      end else begin
         taps = {1'b0, fine_clamped};
      end
      if (timing_q.ecc_en) begin
         eff_stage = rcp_pkg::RCP_STAGE3;
      end else begin
         unique case (timing_q.stage)
            2'h1: eff_stage = rcp_pkg::RCP_STAGE1;
            2'h2: eff_stage = rcp_pkg::RCP_STAGE2;
            default: eff_stage = rcp_pkg::RCP_STAGE3;
         endcase
      end
      unique case (eff_stage)
         rcp_pkg::RCP_STAGE1: eff_code = 2'h1;
         rcp_pkg::RCP_STAGE2: eff_code = 2'h2;
         rcp_pkg::RCP_STAGE3: eff_code = 2'h3;
      endcase
   end

   // Ring read and stage pipeline next values
   always_comb begin
      ring_take = (gray2bin(wgray_sync) != rptr_q);
      rptr_d = ring_take ? rptr_q + 1'b1 : rptr_q;
      stage1_pair = ring_out;
      // Valid rides with the ring's registered read, same edge
      s1_valid_d = ring_take;
      stage2_d = stage1_pair;
      s2_valid_d = s1_valid_q;
      stage3_d = stage2_q;
      s3_valid_d = s2_valid_q;
      // Selected stage feeds the sample flop
      unique case (eff_stage)
         rcp_pkg::RCP_STAGE1: begin
            read_sample_point_flop_d = stage1_pair;
            read_sample_point_flop_valid_d = s1_valid_q;
         end
         rcp_pkg::RCP_STAGE2: begin
            read_sample_point_flop_d = stage2_q;
            read_sample_point_flop_valid_d = s2_valid_q;
         end
         rcp_pkg::RCP_STAGE3: begin
            read_sample_point_flop_d = stage3_q;
            read_sample_point_flop_valid_d = s3_valid_q;
         end
      endcase
      // Hold last sample when nothing new arrives
      if (!read_sample_point_flop_valid_d) begin
         read_sample_point_flop_d = read_sample_point_flop_q;
      end
      count_d = read_sample_point_flop_valid_d ? count_q + 16'h0001 : count_q;
   end

   // Pipeline registers; stage one output is the ring's registered read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rptr_q <= '0;
         s1_valid_q <= 1'b0;
         stage2_q <= '0;
         s2_valid_q <= 1'b0;
         stage3_q <= '0;
         s3_valid_q <= 1'b0;
         read_sample_point_flop_q <= '0;
         read_sample_point_flop_valid_q <= 1'b0;
         count_q <= '0;
      end else begin
         rptr_q <= rptr_d;
         s1_valid_q <= s1_valid_d;
         stage2_q <= stage2_d;
         s2_valid_q <= s2_valid_d;
         stage3_q <= stage3_d;
         s3_valid_q <= s3_valid_d;
         read_sample_point_flop_q <= read_sample_point_flop_d;
         read_sample_point_flop_valid_q <= read_sample_point_flop_valid_d;
         count_q <= count_d;
      end
   end

   // APB decode, write and read data next values
   always_comb begin
      setup_rd = psel && !penable && !pwrite;
      access_wr = psel && penable && pwrite;
      mapped = (paddr == rcp_pkg::OFS_READ_TIMING) || (paddr == rcp_pkg::OFS_STATUS) ||
         (paddr == rcp_pkg::OFS_SAMPLE_HI_DATA) || (paddr == rcp_pkg::OFS_SAMPLE_LO_DATA) ||
         (paddr == rcp_pkg::OFS_SAMPLE_CHECK);
      timing_d = timing_q;
      // Software sets the read clock delay
      if (access_wr && (paddr == rcp_pkg::OFS_READ_TIMING)) begin
         timing_d.fine = pwdata[rcp_pkg::FLD_FINE_MSB:rcp_pkg::FLD_FINE_LSB];
         timing_d.half = pwdata[rcp_pkg::FLD_HALF_BIT];
         timing_d.stage = pwdata[rcp_pkg::FLD_STAGE_MSB:rcp_pkg::FLD_STAGE_LSB];
         timing_d.ecc_en = pwdata[rcp_pkg::FLD_ECC_BIT];
      end
      prdata_d = prdata_q;
      slverr_d = slverr_q;
      if (psel && !penable) begin
         // Error answer on unmapped address
         slverr_d = !mapped;
      end
      if (setup_rd) begin
         prdata_d = 32'h0000_0000;
         unique case (paddr)
            rcp_pkg::OFS_READ_TIMING: begin
               prdata_d[rcp_pkg::FLD_FINE_MSB:rcp_pkg::FLD_FINE_LSB] = timing_q.fine;
               prdata_d[rcp_pkg::FLD_HALF_BIT] = timing_q.half;
               prdata_d[rcp_pkg::FLD_STAGE_MSB:rcp_pkg::FLD_STAGE_LSB] = timing_q.stage;
               prdata_d[rcp_pkg::FLD_ECC_BIT] = timing_q.ecc_en;
            end
            rcp_pkg::OFS_STATUS: begin
               prdata_d[rcp_pkg::FLD_COUNT_MSB:rcp_pkg::FLD_COUNT_LSB] = count_q;
               prdata_d[rcp_pkg::FLD_EFF_MSB:rcp_pkg::FLD_EFF_LSB] = eff_code;
               prdata_d[rcp_pkg::FLD_TAPS_MSB:rcp_pkg::FLD_TAPS_LSB] = taps;
            end
            rcp_pkg::OFS_SAMPLE_HI_DATA: prdata_d = read_sample_point_flop_q.hi.data;
            rcp_pkg::OFS_SAMPLE_LO_DATA: prdata_d = read_sample_point_flop_q.lo.data;
            rcp_pkg::OFS_SAMPLE_CHECK: prdata_d[15:0] = {read_sample_point_flop_q.hi.check, read_sample_point_flop_q.lo.check};
            default: prdata_d = 32'h0000_0000;
         endcase
      end
   end

   // Register file flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timing_q.fine <= rcp_pkg::RST_FINE;
         timing_q.half <= rcp_pkg::RST_HALF;
         timing_q.stage <= rcp_pkg::RST_STAGE;
         timing_q.ecc_en <= rcp_pkg::RST_ECC;
         prdata_q <= 32'h0000_0000;
         slverr_q <= 1'b0;
      end else begin
         timing_q <= timing_d;
         prdata_q <= prdata_d;
         slverr_q <= slverr_d;
      end
   end

   // Outputs
   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = slverr_q && psel && penable;
   // Memory clock follows bus clock in phase
   assign memory_clock_out = pclk;
   // Delay line tap for the read clock
   assign read_clock_delay_taps = taps;
   assign ecc_check_en = timing_q.ecc_en;
   assign sample_valid = read_sample_point_flop_valid_q;
   assign sample_pair = read_sample_point_flop_q;
endmodule

// ### logic/rcp_pkg.sv
// Constants, field layouts and carriers for the DDR read capture path
// How it works
// - Read clock derived from bus clock, delayable
// - Fine field delays zero to half cycle
// - Half bit adds half cycle to fine
// - Data latched by quarter-cycle delayed strobe
// - Three stages, selectable one feeds sample flop
// - Undelayed clock, early data: stage one allowed
// - No check bits, near half delay: stage two
// - Check bits enabled force stage three
// - Stage three without checking still correct, slower
// - Memory clock same frequency, in phase
package rcp_pkg;
   // Lane widths
   localparam int DATA_W = 32;
   localparam int CHECK_W = 8;
   // Capture ring depth and pointer widths
   localparam int RING_AW = 3;
   localparam int PTR_W = RING_AW + 1;
   // Fine delay steps that make up half a bus clock cycle
   localparam logic [3:0] FINE_HALF_STEPS = 4'h8;
   localparam int TAP_W = 5;
   // Register byte offsets
   localparam logic [7:0] OFS_READ_TIMING = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_SAMPLE_HI_DATA = 8'h08;
   localparam logic [7:0] OFS_SAMPLE_LO_DATA = 8'h0c;
   localparam logic [7:0] OFS_SAMPLE_CHECK = 8'h10;
   // Timing register field positions
   localparam int FLD_FINE_LSB = 0;
   localparam int FLD_FINE_MSB = 3;
   localparam int FLD_HALF_BIT = 4;
   localparam int FLD_STAGE_LSB = 8;
   localparam int FLD_STAGE_MSB = 9;
   localparam int FLD_ECC_BIT = 12;
   // Status register field positions
   localparam int FLD_COUNT_LSB = 0;
   localparam int FLD_COUNT_MSB = 15;
   localparam int FLD_EFF_LSB = 16;
   localparam int FLD_EFF_MSB = 17;
   localparam int FLD_TAPS_LSB = 20;
   localparam int FLD_TAPS_MSB = 24;
   // Reset values
   localparam logic [3:0] RST_FINE = 4'h0;
   localparam logic RST_HALF = 1'b0;
   localparam logic [1:0] RST_STAGE = 2'h3;
   localparam logic RST_ECC = 1'b0;

   // Stage choice, one-hot
   typedef enum logic [2:0] {
      RCP_STAGE1 = 3'b001,
      RCP_STAGE2 = 3'b010,
      RCP_STAGE3 = 3'b100
   } rcp_stage_e;

   // One beat on the data and check lanes
   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [CHECK_W-1:0] check;
   } rcp_beat_s;

   // A rising/falling beat pair
   typedef struct packed {
      rcp_beat_s hi;
      rcp_beat_s lo;
   } rcp_pair_s;

   // Software view of the read timing register
   typedef struct packed {
      logic [3:0] fine;
      logic half;
      logic [1:0] stage;
      logic ecc_en;
   } rcp_timing_s;

   localparam int PAIR_W = $bits(rcp_pair_s);
endpackage

// ### logic/rcp_sync.sv
// Two-flop synchroniser for a vector that changes one bit at a time
`timescale 1ns/1ps
module rcp_sync #(
   parameter int W = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   // First stage, read only by the second
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   // Next values
   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   // Two flops in a row
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;
endmodule

// ### logic/rcp_ring.sv
// Small dual-clock ring of captured beat pairs with registered read data
`timescale 1ns/1ps
module rcp_ring #(
   parameter int W = 80,
   parameter int AW = 3
) (
   input wire logic wclk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [W-1:0] wdata,
   input wire logic rclk,
   input wire logic [AW-1:0] raddr,
   output logic [W-1:0] rdata
);
   // Storage, written only on the write clock
   logic [W-1:0] mem [0:(1<<AW)-1];
   // Registered read data on the read clock
   logic [W-1:0] rdata_q;

   // Write port
   always_ff @(posedge wclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // Read port, address held stable by the caller until the pointer is seen
   always_ff @(posedge rclk) begin
      rdata_q <= mem[raddr];
   end

   assign rdata = rdata_q;
endmodule

// ### test/rcp_properties.sv
// Port-level checks for the read capture path
`timescale 1ns/1ps
module rcp_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic memory_clock_out,
   input wire logic [4:0] read_clock_delay_taps,
   input wire logic ecc_check_en,
   input wire logic sample_valid,
   input wire rcp_pkg::rcp_pair_s sample_pair
);
   logic [31:0] tim_q; // Shadow of the timing word
   logic [31:0] tim_d;
   // Shadow follows completed timing writes
   always_comb begin
      tim_d = (psel && penable && pwrite && paddr == 8'h00) ? pwdata : tim_q;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tim_q <= 32'h0000_0300;
      end else begin
         tim_q <= tim_d;
      end
   end
   // Expected delay taps from a timing word
   function automatic logic [4:0] taps_f(input logic [31:0] w);
      logic [4:0] f;
      f = (w[3:0] > 4'h8) ? 5'h08 : {1'b0, w[3:0]};
      return w[4] ? f + 5'h08 : f;
   endfunction
   // Expected effective stage
   function automatic logic [1:0] eff_f(input logic [31:0] w);
      return (w[12] || w[9:8] == 2'h0) ? 2'h3 : w[9:8];
   endfunction
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_mclk_low; !memory_clock_out; endproperty
   a_mclk_low: assert property (p_mclk_low) else $error("clock out high at rise");
   property p_mclk_high; @(negedge pclk) memory_clock_out; endproperty
   a_mclk_high: assert property (p_mclk_high) else $error("clock out low at fall");
   property p_ready; psel && penable |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("access not ready");
   property p_err;
      psel && penable |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10});
   endproperty
   a_err: assert property (p_err) else $error("wrong error response");
   property p_err_idle; !(psel && penable) |-> !pslverr; endproperty
   a_err_idle: assert property (p_err_idle) else $error("error outside access");
   property p_taps; read_clock_delay_taps == taps_f(tim_q); endproperty
   a_taps: assert property (p_taps) else $error("delay taps wrong");
   property p_ecc; ecc_check_en == tim_q[12]; endproperty
   a_ecc: assert property (p_ecc) else $error("check enable wrong");
   property p_stage_rd;
      psel && penable && !pwrite && paddr == 8'h04 |-> prdata[17:16] == eff_f(tim_q);
   endproperty
   a_stage_rd: assert property (p_stage_rd) else $error("effective stage wrong");
   property p_hold; !sample_valid |-> $stable(sample_pair); endproperty
   a_hold: assert property (p_hold) else $error("sample changed without valid");
   c_valid: cover property (sample_valid);
   c_err: cover property (pslverr);
   c_ecc: cover property ($rose(ecc_check_en));
endmodule
bind rcp_top rcp_properties i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .memory_clock_out(memory_clock_out),
   .read_clock_delay_taps(read_clock_delay_taps), .ecc_check_en(ecc_check_en),
   .sample_valid(sample_valid), .sample_pair(sample_pair));

// ### test/rcp_mem_model.sv
// Behavioural memory returning strobed read bursts
`timescale 1ns/1ps
module rcp_mem_model (
   input wire logic go,
   input wire logic [31:0] base,
   output logic capture_clk,
   output logic [31:0] memory_data_lines,
   output logic [7:0] check_bit_lines
);
   // Beat j of the burst seeded by base
   function automatic logic [39:0] beat(input int j);
      logic [31:0] d;
      d = base + 32'(j) * 32'h01010101;
      return {d, d[7:0] ^ 8'h5a};
   endfunction
   // Strobe idles low, lanes idle
   initial begin
      capture_clk = 1'b0;
      {memory_data_lines, check_bit_lines} = 40'h0;
   end
   always @(posedge go) begin
      #(base[2:0]);
      for (int k = 0; k < 8; k++) begin
         {memory_data_lines, check_bit_lines} = beat(k);
         #3 capture_clk = ~capture_clk;
         // Hold expired, lanes show garbage
         #1 {memory_data_lines, check_bit_lines} = ~beat(k);
         #2;
      end
   end
endmodule

// ### test/tb_top.sv
// Self-checking bench for the read capture path
`timescale 1ns/1ps
module tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic cclk;
   logic [31:0] mdata;
   logic [7:0] mcheck;
   logic mclk;
   logic [4:0] taps;
   logic ecc_en;
   logic svalid;
   rcp_pkg::rcp_pair_s spair;
   logic go = 1'b0;
   logic [31:0] base = 32'h0;
   logic [31:0] lfsr_q = 32'h9461; // Random source
   logic [31:0] rd;
   logic [31:0] w;
   logic [15:0] cnt = 16'h0;
   logic err;
   logic [12:0] cfg [6] = '{13'h0100, 13'h0217, 13'h1109, 13'h0318, 13'h000f, 13'h0200};
   logic [79:0] exp_last; // Expected last pair of the final burst
   int bad_count = 0;
   int checks_done = 0;
   int lat;
   int lat1;
   rcp_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .capture_clk(cclk), .memory_data_lines(mdata),
      .check_bit_lines(mcheck), .memory_clock_out(mclk), .read_clock_delay_taps(taps),
      .ecc_check_en(ecc_en), .sample_valid(svalid), .sample_pair(spair));
   rcp_mem_model i_mem (.go(go), .base(base), .capture_clk(cclk),
      .memory_data_lines(mdata), .check_bit_lines(mcheck));
   // Bus clock
   always #25 pclk = ~pclk;
   // Next random word
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Expected delay taps
   function automatic logic [4:0] exp_taps(input logic [31:0] v);
      logic [4:0] f;
      f = (v[3:0] > 4'h8) ? 5'h08 : {1'b0, v[3:0]};
      return v[4] ? f + 5'h08 : f;
   endfunction
   // Expected effective stage
   function automatic logic [1:0] exp_stage(input logic [31:0] v);
      return (v[12] || v[9:8] == 2'h0) ? 2'h3 : v[9:8];
   endfunction
   // Expected pair k of a burst
   function automatic logic [79:0] exp_pair(input logic [31:0] b, input int k);
      logic [31:0] d0;
      logic [31:0] d1;
      d0 = b + 32'(2 * k) * 32'h01010101;
      d1 = b + 32'(2 * k + 1) * 32'h01010101;
      return {d0, d0[7:0] ^ 8'h5a, d1, d1[7:0] ^ 8'h5a};
   endfunction
   // Compare and count
   task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer, held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      // Answer taken at the completing edge only
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Four-pair burst, collects samples and latency
   task automatic burst();
      int got;
      got = 0;
      lfsr_q = lfsr(lfsr_q);
      base <= lfsr_q;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      for (int n = 0; n < 40; n++) begin
         @(negedge pclk);
         if (svalid === 1'b1) begin
            if (got == 0) lat = n;
            chk(spair, exp_pair(base, got));
            got++;
         end
      end
      chk(80'(got), 80'd4);
   endtask
   // Verdict and end of run
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Hang guard
   initial begin
      #200000;
      bad_count++;
      stop_test();
   end
   // Main sequence
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd & 32'h1313, 32'h0300);
      apb(1'b0, 8'h14, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      for (int i = 0; i < 6; i++) begin
         w = (i == 5) ? (lfsr_q & 32'h1313) : {19'h0, cfg[i]};
         apb(1'b1, 8'h00, w);
         chk(taps, exp_taps(w));
         chk(ecc_en, w[12]);
         burst();
         if (i == 0) lat1 = lat;
         chk(80'(lat - lat1), 80'(exp_stage(w) - 2'd1));
         apb(1'b1, 8'h04, 32'hffff_ffff);
         apb(1'b0, 8'h04, 32'h0);
         chk({rd[24:20], rd[17:16]}, {exp_taps(w), exp_stage(w)});
         cnt = cnt + 16'd4;
         chk(rd[15:0], cnt);
      end
      exp_last = exp_pair(base, 3);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, exp_last[79:48]);
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd, exp_last[39:8]);
      apb(1'b0, 8'h10, 32'h0);
      chk(rd[15:0], {exp_last[47:40], exp_last[7:0]});
      stop_test();
   end
endmodule
